// ===== tb.sv
`timescale 1ns/10ps
module tb
  import uim_pkg::*;
;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  uim_bus_req_t busReq = '0;
  logic sofValid = 1'b0;
  logic [10:0] sofFrame = 11'h000;
  logic [6:0] devAddress = 7'h00;
  logic decodeLineState = 1'b0;
  logic resumeSe0 = 1'b0;
  logic resumeK = 1'b0;
  logic [31:0] busRdata;
  logic busRvalid, rxActive, rxError, packetStart, dataCrcFail;
  logic [1:0] lineState, filteredLineState;
  logic [3:0] packetPid;
  uim_token_t token;
  logic eventPortN, eventPortO, eventPortP, eventPortQ;
  logic [4:0] rxEndpoint;
  logic pulldownDisable, autoResumeEnable;
  logic [2:0] phyConfPins;
  logic [8:0] powerSignal;
  int n_fail = 0;
  int n_checks = 0;
  localparam logic [7:0] RW_ADR[9] = '{OFS_STICKY, OFS_MASKS, OFS_SOF, OFS_EP_MARK,
    OFS_SESSION, OFS_POWER, OFS_PHY, OFS_PID, OFS_ENDPOINT};
  // bits 13:12 of the phy register only clear on write, so ones read back zero
  localparam logic [31:0] RW_MSK[9] = '{32'h7F, 32'hFFFF_FFFF, 32'h7FF, 32'hFFFF,
    32'hFFFF_FFFF, 32'h1FF, 32'h0004_0FF0, 32'h0, 32'h0};

  always #5 sys_clk = ~sys_clk;

  uim_phy_model u_phy (.sys_clk(sys_clk), .lineState(lineState), .rxActive(rxActive),
    .rxError(rxError), .packetStart(packetStart), .packetPid(packetPid), .token(token),
    .dataCrcFail(dataCrcFail));

  usb_interface_manager u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .busReq(busReq),
    .busRdata(busRdata), .busRvalid(busRvalid), .lineState(lineState),
    .rxActive(rxActive), .rxError(rxError), .packetStart(packetStart),
    .packetPid(packetPid), .token(token), .dataCrcFail(dataCrcFail), .sofValid(sofValid),
    .sofFrame(sofFrame), .devAddress(devAddress), .decodeLineState(decodeLineState),
    .resumeSe0(resumeSe0), .resumeK(resumeK), .eventPortN(eventPortN),
    .eventPortO(eventPortO), .eventPortP(eventPortP), .eventPortQ(eventPortQ),
    .rxEndpoint(rxEndpoint), .pulldownDisable(pulldownDisable),
    .autoResumeEnable(autoResumeEnable), .phyConfPins(phyConfPins),
    .filteredLineState(filteredLineState), .powerSignal(powerSignal));

  task automatic final_report();
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    busReq <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    busReq <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    busReq <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
    check("read valid", 32'h1, {31'h0, busRvalid});
    check($sformatf("register %h", a), exp, busRdata);
  endtask : rd

  task automatic ports(input logic [3:0] exp);
    check("event ports QPON", {28'h0, exp},
      {28'h0, eventPortQ, eventPortP, eventPortO, eventPortN});
  endtask : ports

  // the filter time is bounded: a wait longer than 8 cycles is a failure
  task automatic wait_line(input logic [1:0] s);
    int k;
    k = 0;
    while (filteredLineState !== s && k < 8)
    begin
      cyc(1);
      k++;
    end
    check("filtered line", {30'h0, s}, {30'h0, filteredLineState});
    if (k >= 8)
      final_report();
  endtask : wait_line

  initial
  begin
    repeat (20) @(posedge sys_clk);
    check("filtered line", 32'h1, {30'h0, filteredLineState});
    arst_n <= 1'b1;
    rd(OFS_FLAGS, 32'h0);
    foreach (RW_ADR[i]) rd(RW_ADR[i], 32'h0);
    rd(8'h44, 32'h0);
    foreach (RW_ADR[i]) wr(RW_ADR[i], 32'hFFFF_FFFF);
    foreach (RW_ADR[i]) rd(RW_ADR[i], RW_MSK[i]);
    cyc(2);
    check("phy outputs", 32'h3FFF,
      {18'h0, pulldownDisable, autoResumeEnable, phyConfPins, powerSignal});
    ports(4'h0);
    foreach (RW_ADR[i]) wr(RW_ADR[i], 32'h0);
    wr(OFS_PHY, 32'h50);
    wr(OFS_POWER, 32'h1A5);
    cyc(2);
    check("phy outputs", 32'h0BA5,
      {18'h0, pulldownDisable, autoResumeEnable, phyConfPins, powerSignal});
    @(posedge sys_clk);
    devAddress <= 7'h05;
    wr(OFS_MASKS, 32'h0102_0440);
    wr(OFS_EP_MARK, 32'h0008);
    u_phy.send_token(7'h05, 4'h3, 1'b1);
    cyc(3);
    check("rx endpoint", 32'h13, {27'h0, rxEndpoint});
    ports(4'h1);
    rd(OFS_FLAGS, 32'h40);
    rd(OFS_ENDPOINT, 32'h13);
    u_phy.send_packet(4'h9);
    cyc(2);
    rd(OFS_PID, 32'h9);
    rd(OFS_FLAGS, 32'h0);
    u_phy.send_token(7'h06, 4'h7, 1'b1);
    u_phy.send_token(7'h05, 4'h7, 1'b0);
    cyc(3);
    rd(OFS_FLAGS, 32'h0);
    rd(OFS_ENDPOINT, 32'h13);
    u_phy.send_token(7'h05, 4'h2, 1'b1);
    cyc(3);
    check("rx endpoint", 32'h02, {27'h0, rxEndpoint});
    wr(OFS_STICKY, 32'h4);
    u_phy.data_bad();
    cyc(3);
    ports(4'h3);
    u_phy.send_packet(4'h3);
    cyc(2);
    rd(OFS_FLAGS, 32'h4);
    wr(OFS_FLAGS, 32'h4);
    rd(OFS_FLAGS, 32'h0);
    u_phy.set_rx(1'b1, 1'b1);
    cyc(3);
    ports(4'hC);
    rd(OFS_FLAGS, 32'h3);
    u_phy.set_rx(1'b0, 1'b0);
    cyc(2);
    rd(OFS_FLAGS, 32'h0);
    @(posedge sys_clk);
    sofFrame <= 11'h5A5;
    sofValid <= 1'b1;
    @(posedge sys_clk);
    sofValid <= 1'b0;
    rd(OFS_SOF, 32'h5A5);
    wr(OFS_PHY, 32'h200);
    u_phy.set_line(LINE_K);
    cyc(2);
    check("filtered line", {30'h0, LINE_J}, {30'h0, filteredLineState});
    wait_line(LINE_K);
    rd(OFS_FLAGS, 32'h0);
    @(posedge sys_clk);
    decodeLineState <= 1'b1;
    cyc(2);
    rd(OFS_FLAGS, 32'h10);
    u_phy.set_line(LINE_SE0);
    cyc(2);
    wait_line(LINE_SE0);
    rd(OFS_FLAGS, 32'h30);
    u_phy.set_line(LINE_J);
    cyc(2);
    wait_line(LINE_J);
    rd(OFS_FLAGS, 32'h38);
    @(posedge sys_clk);
    resumeSe0 <= 1'b1;
    @(posedge sys_clk);
    resumeSe0 <= 1'b0;
    rd(OFS_PHY, 32'h2200);
    wr(OFS_PHY, 32'h2200);
    rd(OFS_PHY, 32'h2200);
    wr(OFS_PHY, 32'h200);
    rd(OFS_PHY, 32'h200);
    @(posedge sys_clk);
    resumeK <= 1'b1;
    @(posedge sys_clk);
    resumeK <= 1'b0;
    rd(OFS_PHY, 32'h1200);
    wr(OFS_PHY, 32'h200);
    rd(OFS_PHY, 32'h200);
    final_report();
  end
endmodule : tb

// ===== uim_line_filter.sv
`timescale 1ns/10ps
module uim_line_filter
  import uim_pkg::*;
#(
  parameter int CNT_W = FILTER_CNT_W
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [1:0] rawState,
  input wire logic [3:0] log2Delay,
  output logic [1:0] filtState
);
  logic [1:0] candidate;
  logic [CNT_W-1:0] count;
  logic [1:0] next_candidate;
  logic [CNT_W-1:0] next_count;
  logic [1:0] next_filtState;
  logic [CNT_W:0] limit;

  // a new level must stay put for 2**log2Delay clocks before it shows
  always_comb
  begin
    limit = (CNT_W+1)'(1) << log2Delay;
    next_candidate = candidate;
    next_count = count;
    next_filtState = filtState;
    if (rawState != candidate)
    begin
      next_candidate = rawState;
      next_count = '0;
    end
    else if (filtState != candidate)
    begin
      if ({1'b0, count} + (CNT_W+1)'(1) >= limit)
        next_filtState = candidate;
      else
        next_count = count + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      candidate <= LINE_J;
      count <= '0;
      filtState <= LINE_J;
    end
    else
    begin
      candidate <= next_candidate;
      count <= next_count;
      filtState <= next_filtState;
    end
  end
endmodule : uim_line_filter

// ===== uim_phy_model.sv
`timescale 1ns/10ps
module uim_phy_model
  import uim_pkg::*;
(
  input wire logic sys_clk,
  output logic [1:0] lineState,
  output logic rxActive,
  output logic rxError,
  output logic packetStart,
  output logic [3:0] packetPid,
  output uim_token_t token,
  output logic dataCrcFail
);
  initial
  begin
    lineState = LINE_J;
    rxActive = 1'b0;
    rxError = 1'b0;
    packetStart = 1'b0;
    packetPid = 4'h0;
    token = '0;
    dataCrcFail = 1'b0;
  end

  // pid and token fields only mean something with their strobe; scrambled after
  task automatic send_packet(input logic [3:0] pid);
    @(posedge sys_clk);
    packetStart <= 1'b1;
    packetPid <= pid;
    @(posedge sys_clk);
    packetStart <= 1'b0;
    packetPid <= ~pid;
  endtask : send_packet

  task automatic send_token(input logic [6:0] adr, input logic [3:0] ep, input logic good);
    @(posedge sys_clk);
    token <= '{1'b1, good, 1'b1, adr, ep};
    @(posedge sys_clk);
    token <= '{1'b0, ~good, 1'b0, ~adr, ~ep};
  endtask : send_token

  task automatic data_bad();
    @(posedge sys_clk);
    dataCrcFail <= 1'b1;
    @(posedge sys_clk);
    dataCrcFail <= 1'b0;
  endtask : data_bad

  task automatic set_rx(input logic act, input logic err);
    @(posedge sys_clk);
    rxActive <= act;
    rxError <= err;
  endtask : set_rx

  task automatic set_line(input logic [1:0] s);
    @(posedge sys_clk);
    lineState <= s;
  endtask : set_line
endmodule : uim_phy_model

// ===== uim_pkg.sv
// Behaviour
// - non-sticky flags clear when next packet arrives
// - valid addressed token sets flag bit 6
// - SE0, K, J line states set bits 5,4,3
// - data CRC16 failure sets flag bit 2
// - bits 1,0 follow receive-active and receive-error
// - sticky mask holds flag until written one
// - event ports are OR of masked flags
// - 11-bit read-write start-of-frame counter
// - last received PID captured read-only
// - last endpoint kept, bit 4 marks valid
// - marked endpoints delivered ORed with 0x10
// - PHY-control bit 18 disables data pulldowns
// - SE0 auto-resume sets bit 13, write zero clears
// - K auto-resume sets bit 12, write zero clears
// - line-state changes delayed two-power-field clocks
// - bit 7 hands resume to suspend controller
// - PHY config pins driven from field 6:4
// - only tokens to stored address count
// - line symbols decoded only when decoder enabled
package uim_pkg;
  localparam logic [7:0] OFS_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_STICKY = 8'h20;
  localparam logic [7:0] OFS_MASKS = 8'h24;
  localparam logic [7:0] OFS_SOF = 8'h28;
  localparam logic [7:0] OFS_PID = 8'h2C;
  localparam logic [7:0] OFS_ENDPOINT = 8'h30;
  localparam logic [7:0] OFS_EP_MARK = 8'h34;
  localparam logic [7:0] OFS_SESSION = 8'h38;
  localparam logic [7:0] OFS_POWER = 8'h3C;
  localparam logic [7:0] OFS_PHY = 8'h40;

  localparam int FLAG_TOKEN = 6;
  localparam int FLAG_SE0 = 5;
  localparam int FLAG_K = 4;
  localparam int FLAG_J = 3;
  localparam int FLAG_CRC = 2;
  localparam int FLAG_RXACT = 1;
  localparam int FLAG_RXERR = 0;
  localparam int FLAG_W = 7;

  localparam int PHY_PULLDOWN_OFF = 18;
  localparam int PHY_RESUME_SE0 = 13;
  localparam int PHY_RESUME_K = 12;
  localparam int PHY_FILTER_LSB = 8;
  localparam int PHY_AUTO_RESUME = 7;
  localparam int PHY_CONF_LSB = 4;
  localparam logic [31:0] PHY_RW_BITS = 32'h0004_3FF0;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  localparam int EP_VALID_BIT = 4;
  localparam logic [4:0] EP_MARK_OR = 5'h10;

  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J = 2'h1;
  localparam logic [1:0] LINE_K = 2'h2;

  localparam int FILTER_CNT_W = 16;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [31:0] wdata;
  } uim_bus_req_t;

  typedef struct packed {
    logic valid;
    logic crc5Ok;
    logic pidOk;
    logic [6:0] addr;
    logic [3:0] endpoint;
  } uim_token_t;
endpackage : uim_pkg

// ===== usb_interface_manager.sv
`timescale 1ns/10ps
module usb_interface_manager
  import uim_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire uim_bus_req_t busReq,
  output logic [31:0] busRdata,
  output logic busRvalid,
  input wire logic [1:0] lineState,
  input wire logic rxActive,
  input wire logic rxError,
  input wire logic packetStart,
  input wire logic [3:0] packetPid,
  input wire uim_token_t token,
  input wire logic dataCrcFail,
  input wire logic sofValid,
  input wire logic [10:0] sofFrame,
  input wire logic [6:0] devAddress,
  input wire logic decodeLineState,
  input wire logic resumeSe0,
  input wire logic resumeK,
  output logic eventPortN,
  output logic eventPortO,
  output logic eventPortP,
  output logic eventPortQ,
  output logic [4:0] rxEndpoint,
  output logic pulldownDisable,
  output logic autoResumeEnable,
  output logic [2:0] phyConfPins,
  output logic [1:0] filteredLineState,
  output logic [8:0] powerSignal
);
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] stickyMask;
  logic [31:0] portMasks;
  logic [10:0] sofCount;
  logic [3:0] lastPid;
  logic [4:0] lastEndpoint;
  logic [15:0] markMask;
  logic [31:0] sessionMask;
  logic [8:0] powerReg;
  logic [31:0] phyCtl;
  logic [1:0] filtState;

  logic [FLAG_W-1:0] next_flags;
  logic [FLAG_W-1:0] next_stickyMask;
  logic [31:0] next_portMasks;
  logic [10:0] next_sofCount;
  logic [3:0] next_lastPid;
  logic [4:0] next_lastEndpoint;
  logic [15:0] next_markMask;
  logic [31:0] next_sessionMask;
  logic [8:0] next_powerReg;
  logic [31:0] next_phyCtl;
  logic [31:0] next_busRdata;
  logic [4:0] next_rxEndpoint;

  logic tokenHit;
  logic [FLAG_W-1:0] flagSet;
  logic [FLAG_W-1:0] flagClr;
  logic [31:0] readMux;

  uim_line_filter #(
    .CNT_W(FILTER_CNT_W)
  ) u_filter (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .rawState(lineState),
    .log2Delay(phyCtl[PHY_FILTER_LSB +: 4]),
    .filtState(filtState)
  );

  // address check lives here so a mismatched token never raises a flag
  assign tokenHit = token.valid && token.crc5Ok && token.pidOk
                    && (token.addr == devAddress);

  always_comb
  begin
    flagSet = '0;
    flagSet[FLAG_TOKEN] = tokenHit;
    flagSet[FLAG_SE0] = decodeLineState && (filtState == LINE_SE0);
    flagSet[FLAG_K] = decodeLineState && (filtState == LINE_K);
    flagSet[FLAG_J] = decodeLineState && (filtState == LINE_J);
    flagSet[FLAG_CRC] = dataCrcFail;
    flagSet[FLAG_RXACT] = rxActive;
    flagSet[FLAG_RXERR] = rxError;
    flagClr = '0;
    if (busReq.write && busReq.addr == OFS_FLAGS)
      flagClr = busReq.wdata[FLAG_W-1:0];
    if (packetStart)
      flagClr = flagClr | ~stickyMask;
  end

  always_comb
  begin
    next_flags = (flags & ~flagClr) | flagSet; // set beats clear
    // non-sticky line copies track the input rather than latching it
    next_flags[FLAG_RXACT] = stickyMask[FLAG_RXACT] ?
      ((flags[FLAG_RXACT] & ~flagClr[FLAG_RXACT]) | rxActive) : rxActive;
    next_flags[FLAG_RXERR] = stickyMask[FLAG_RXERR] ?
      ((flags[FLAG_RXERR] & ~flagClr[FLAG_RXERR]) | rxError) : rxError;
    next_stickyMask = stickyMask;
    next_portMasks = portMasks;
    next_sofCount = sofCount;
    next_lastPid = lastPid;
    next_lastEndpoint = lastEndpoint;
    next_markMask = markMask;
    next_sessionMask = sessionMask;
    next_powerReg = powerReg;
    next_phyCtl = phyCtl;
    next_rxEndpoint = rxEndpoint;
    if (busReq.write)
    begin
      if (busReq.addr == OFS_STICKY)
        next_stickyMask = busReq.wdata[FLAG_W-1:0];
      else if (busReq.addr == OFS_MASKS)
        next_portMasks = busReq.wdata;
      else if (busReq.addr == OFS_SOF)
        next_sofCount = busReq.wdata[10:0];
      else if (busReq.addr == OFS_EP_MARK)
        next_markMask = busReq.wdata[15:0];
      else if (busReq.addr == OFS_SESSION)
        next_sessionMask = busReq.wdata;
      else if (busReq.addr == OFS_POWER)
        next_powerReg = busReq.wdata[8:0];
      else if (busReq.addr == OFS_PHY)
      begin
        // resume cause bits only clear from software, a one keeps them
        next_phyCtl = busReq.wdata & PHY_RW_BITS;
        next_phyCtl[PHY_RESUME_SE0] = phyCtl[PHY_RESUME_SE0]
                                      & busReq.wdata[PHY_RESUME_SE0];
        next_phyCtl[PHY_RESUME_K] = phyCtl[PHY_RESUME_K]
                                    & busReq.wdata[PHY_RESUME_K];
      end
    end
    if (resumeSe0)
      next_phyCtl[PHY_RESUME_SE0] = 1'b1;
    if (resumeK)
      next_phyCtl[PHY_RESUME_K] = 1'b1;
    if (sofValid)
      next_sofCount = sofFrame;
    if (packetStart)
      next_lastPid = packetPid;
    if (tokenHit)
    begin
      next_lastEndpoint = {1'b1, token.endpoint};
      next_rxEndpoint = {1'b0, token.endpoint}
                        | (markMask[token.endpoint] ? EP_MARK_OR : 5'h00);
    end
  end

  // reads outside this block's range answer zero
  always_comb
  begin
    readMux = 32'h0000_0000;
    if (busReq.addr == OFS_FLAGS)
      readMux = {25'h0, flags};
    else if (busReq.addr == OFS_STICKY)
      readMux = {25'h0, stickyMask};
    else if (busReq.addr == OFS_MASKS)
      readMux = portMasks;
    else if (busReq.addr == OFS_SOF)
      readMux = {21'h0, sofCount};
    else if (busReq.addr == OFS_PID)
      readMux = {28'h0, lastPid};
    else if (busReq.addr == OFS_ENDPOINT)
      readMux = {27'h0, lastEndpoint};
    else if (busReq.addr == OFS_EP_MARK)
      readMux = {16'h0, markMask};
    else if (busReq.addr == OFS_SESSION)
      readMux = sessionMask;
    else if (busReq.addr == OFS_POWER)
      readMux = {23'h0, powerReg};
    else if (busReq.addr == OFS_PHY)
      readMux = phyCtl;
    next_busRdata = busReq.read ? readMux : 32'h0000_0000;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags <= '0;
      stickyMask <= '0;
      portMasks <= RESET_VALUE;
      sofCount <= '0;
      lastPid <= '0;
      lastEndpoint <= '0;
      markMask <= '0;
      sessionMask <= RESET_VALUE;
      powerReg <= '0;
      phyCtl <= RESET_VALUE;
      busRdata <= 32'h0000_0000;
      busRvalid <= 1'b0;
      rxEndpoint <= '0;
      eventPortN <= 1'b0;
      eventPortO <= 1'b0;
      eventPortP <= 1'b0;
      eventPortQ <= 1'b0;
      pulldownDisable <= 1'b0;
      autoResumeEnable <= 1'b0;
      phyConfPins <= '0;
      filteredLineState <= LINE_J;
      powerSignal <= '0;
    end
    else
    begin
      flags <= next_flags;
      stickyMask <= next_stickyMask;
      portMasks <= next_portMasks;
      sofCount <= next_sofCount;
      lastPid <= next_lastPid;
      lastEndpoint <= next_lastEndpoint;
      markMask <= next_markMask;
      sessionMask <= next_sessionMask;
      powerReg <= next_powerReg;
      phyCtl <= next_phyCtl;
      busRdata <= next_busRdata;
      busRvalid <= busReq.read;
      rxEndpoint <= next_rxEndpoint;
      eventPortN <= |(flags & portMasks[FLAG_W-1:0]);
      eventPortO <= |(flags & portMasks[8 +: FLAG_W]);
      eventPortP <= |(flags & portMasks[16 +: FLAG_W]);
      eventPortQ <= |(flags & portMasks[24 +: FLAG_W]);
      pulldownDisable <= phyCtl[PHY_PULLDOWN_OFF];
      autoResumeEnable <= phyCtl[PHY_AUTO_RESUME];
      phyConfPins <= phyCtl[PHY_CONF_LSB +: 3];
      filteredLineState <= filtState;
      powerSignal <= powerReg;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sticky_hold_a: assert property (1 |=> ((($past(flags & stickyMask)
                                  & ~$past(flagClr)) & ~flags) == 0))
    else $error("sticky flag lost without a clear");
  packet_clear_a: assert property (packetStart && !tokenHit && !dataCrcFail
                                   && !decodeLineState && stickyMask == 0 |=> flags[6:2] == 5'h00)
    else $error("non-sticky flags survived a new packet");
  token_flag_a: assert property (tokenHit |=> flags[FLAG_TOKEN])
    else $error("accepted token did not raise its flag");
  token_reject_a: assert property (token.valid && token.addr != devAddress
                                   && !flags[FLAG_TOKEN] |=> !flags[FLAG_TOKEN])
    else $error("foreign-address token raised the flag");
  crc_flag_a: assert property (dataCrcFail |=> flags[FLAG_CRC])
    else $error("data CRC failure not flagged");
  rx_follow_a: assert property (stickyMask[1:0] == 2'h0
                                |=> flags[1:0] == $past({rxActive, rxError}))
    else $error("receive flags do not follow inputs");
  line_decode_a: assert property (!decodeLineState && !packetStart && flags[5:3] == 3'h0
                                  && !(busReq.write && busReq.addr == OFS_STICKY)
                                  |=> flags[5:3] == 3'h0)
    else $error("line symbol flagged with decoder off");
  event_port_a: assert property (1 |=> eventPortN == |($past(flags) & $past(portMasks[6:0])))
    else $error("event port N disagrees with masked flags");
  port_o_a: assert property (1 |=> eventPortO == |($past(flags) & $past(portMasks[14:8])))
    else $error("event port O disagrees with masked flags");
  port_p_a: assert property (1 |=> eventPortP == |($past(flags) & $past(portMasks[22:16])))
    else $error("event port P disagrees with masked flags");
  port_q_a: assert property (1 |=> eventPortQ == |($past(flags) & $past(portMasks[30:24])))
    else $error("event port Q disagrees with masked flags");
  pulldown_ctl_a: assert property (busReq.write && busReq.addr == OFS_PHY
                                   |-> ##2 pulldownDisable
                                   == $past(busReq.wdata[PHY_PULLDOWN_OFF], 2))
    else $error("pulldown disable not taken from control");
  resume_se0_a: assert property (resumeSe0 |=> phyCtl[PHY_RESUME_SE0])
    else $error("SE0 resume cause not recorded");
  resume_k_a: assert property (resumeK |=> phyCtl[PHY_RESUME_K])
    else $error("K resume cause not recorded");
  endpoint_mark_a: assert property (tokenHit
                                    |=> rxEndpoint == {$past(markMask[token.endpoint]),
                                                       $past(token.endpoint)})
    else $error("delivered endpoint mark wrong");
  sof_load_a: assert property (sofValid |=> sofCount == $past(sofFrame))
    else $error("frame counter not loaded");
  sof_write_a: assert property (busReq.write && busReq.addr == OFS_SOF && !sofValid
                                |=> sofCount == $past(busReq.wdata[10:0]))
    else $error("frame counter write lost");
  flag_reserved_a: assert property (busReq.read && busReq.addr == OFS_FLAGS
                                    |=> busRdata[31:7] == 25'h0)
    else $error("reserved flag bits read nonzero");
  phy_reserved_a: assert property ((phyCtl & ~PHY_RW_BITS) == 32'h0000_0000)
    else $error("reserved control bits hold a one");
  conf_pins_a: assert property (1 |=> phyConfPins == $past(phyCtl[PHY_CONF_LSB +: 3]))
    else $error("configuration pins not copied from control");
  auto_resume_a: assert property (1 |=> autoResumeEnable == $past(phyCtl[PHY_AUTO_RESUME]))
    else $error("resume handover bit not copied");
  power_copy_a: assert property (busReq.write && busReq.addr == OFS_POWER
                                 |-> ##2 powerSignal == $past(busReq.wdata[8:0], 2))
    else $error("power signalling output not taken from register");
  pid_capture_a: assert property (packetStart |=> lastPid == $past(packetPid))
    else $error("last packet identifier not captured");
  endpoint_valid_a: assert property (tokenHit
                                     |=> lastEndpoint == {1'b1, $past(token.endpoint)})
    else $error("last endpoint not captured as valid");
  filter_source_a: assert property ($changed(filtState) |-> filtState == $past(lineState))
    else $error("filtered state took a level the line did not hold");
  flag_clear_a: assert property (busReq.write && busReq.addr == OFS_FLAGS
                                 && busReq.wdata[FLAG_CRC] && !dataCrcFail |=> !flags[FLAG_CRC])
    else $error("written one did not clear a flag");

  token_seen_c: cover property (tokenHit ##1 eventPortN);
  sticky_seen_c: cover property (stickyMask[FLAG_CRC] && dataCrcFail
                                 ##1 packetStart ##1 flags[FLAG_CRC]);
  phy_write_seen_c: cover property (busReq.write && busReq.addr == OFS_PHY ##2 pulldownDisable);
  resume_seen_c: cover property (resumeK ##[1:20] (busReq.write && busReq.addr == OFS_PHY));
  read_seen_c: cover property (busReq.read && busReq.addr == OFS_FLAGS ##1 busRvalid);
endmodule : usb_interface_manager
